// ===== core/epc_pkg.sv
package epc_pkg;

   // data-space offsets of the registers
   localparam logic [7:0] OFS_PIN_CHANGE_FLAGS         = 8'h3b;
   localparam logic [7:0] OFS_EXTERNAL_IRQ_FLAGS       = 8'h3c;
   localparam logic [7:0] OFS_EXTERNAL_IRQ_ENABLES     = 8'h3d;
   localparam logic [7:0] OFS_PIN_CHANGE_GROUP_ENABLES = 8'h68;
   localparam logic [7:0] OFS_PIN_CHANGE_LINE_MASK_0   = 8'h6b;
   localparam logic [7:0] OFS_PIN_CHANGE_LINE_MASK_1   = 8'h6c;
   localparam logic [7:0] OFS_PIN_CHANGE_LINE_MASK_2   = 8'h6d;

   // i/o-space alias: data offset minus this, valid up to the limit
   localparam logic [7:0] IO_SPACE_DISTANCE = 8'h20;
   localparam logic [7:0] IO_SPACE_LIMIT    = 8'h3f;

   // reset value shared by every register
   localparam logic [7:0] REG_RESET = 8'h00;

   // field positions
   localparam int BIT_LINE_ZERO  = 0;
   localparam int BIT_LINE_ONE   = 1;
   localparam int BIT_GROUP_ZERO = 0;
   localparam int BIT_GROUP_ONE  = 1;
   localparam int BIT_GROUP_TWO  = 2;

   // pin change line ranges per group
   localparam int GROUP_ZERO_LSB = 0;
   localparam int GROUP_ONE_LSB  = 8;
   localparam int GROUP_TWO_LSB  = 16;
   localparam int GROUP_ONE_BITS = 7;
   localparam int PIN_LINES      = 24;

   // sense field encodings
   localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
   localparam logic [1:0] SENSE_ANY_EDGE  = 2'h1;
   localparam logic [1:0] SENSE_FALLING   = 2'h2;
   localparam logic [1:0] SENSE_RISING    = 2'h3;

   // vector numbers, lowest number wins
   typedef logic [2:0] epc_vector_t;
   localparam epc_vector_t VEC_LINE_ZERO  = 3'h0;
   localparam epc_vector_t VEC_LINE_ONE   = 3'h1;
   localparam epc_vector_t VEC_GROUP_ZERO = 3'h2;
   localparam epc_vector_t VEC_GROUP_ONE  = 3'h3;
   localparam epc_vector_t VEC_GROUP_TWO  = 3'h4;

   // one register access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic       io_space;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } epc_bus_req_s;

endpackage : epc_pkg

// ===== core/epc_pin_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser with a previous sample for change detection
module epc_pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // raw pins
   input  wire logic [WIDTH-1:0] pin_in,
   // synchronised level and one-cycle change marker
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] changed
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] prev;
   logic [2:0]       primed;

   // meta feeds only level; prev holds the last synchronised sample
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta   <= '0;
         level  <= '0;
         prev   <= '0;
         primed <= 3'h0;
      end else begin
         meta   <= pin_in;
         level  <= meta;
         prev   <= level;
         primed <= {primed[1:0], 1'b1};
      end
   end

   // prev holds a real sample only after the third edge; until then a pin
   // that idles high would fake an edge against the reset value
   assign changed = primed[2] ? (level ^ prev) : '0;

endmodule : epc_pin_sync

// ===== core/epc_flag_bits.sv
`timescale 1ns/10ps
// sticky flags: set from hardware, cleared by write-one, by handler entry or by the held level-mode clear
module epc_flag_bits #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // set and clear requests, one cycle each except the level-mode clear, which is held
   input  wire logic [WIDTH-1:0] set,
   input  wire logic [WIDTH-1:0] clear,
   // current flags
   output logic      [WIDTH-1:0] flags
);

   logic [WIDTH-1:0] next_flags;

   // set is or-ed in after the clear so a coincident event survives
   assign next_flags = (flags & ~clear) | set;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

endmodule : epc_flag_bits

// ===== core/epc_irq_ctrl.sv
`timescale 1ns/10ps
module epc_irq_ctrl (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // core side
   input  wire logic                  global_irq_enable,
   input  wire logic                  irq_ack,
   input  wire epc_pkg::epc_vector_t  irq_ack_vector,
   output logic                       irq_request,
   output epc_pkg::epc_vector_t       irq_vector,
   // register access
   input  wire epc_pkg::epc_bus_req_s bus_req,
   output logic [7:0]                 bus_rdata,
   // sense selection per external line
   input  wire logic [1:0]            line_zero_sense,
   input  wire logic [1:0]            line_one_sense,
   // pins
   input  wire logic [1:0]            external_line,
   input  wire logic [23:0]           pin_change_line
);
   import epc_pkg::*;

   // released reset
   logic                 rst_meta_n;
   logic                 rst_sync_n;

   // software registers
   logic [1:0]           external_irq_enables;
   logic [2:0]           pin_change_group_enables;
   logic [7:0]           pin_change_line_mask_zero;
   logic [6:0]           pin_change_line_mask_one;
   logic [7:0]           pin_change_line_mask_two;

   // flags
   logic [1:0]           external_irq_flags;
   logic [2:0]           pin_change_flags;

   // synchronised pins
   logic [1:0]           ext_level;
   logic [1:0]           ext_changed;
   logic [23:0]          pc_level;
   logic [23:0]          pc_changed;

   // address decode
   logic                 io_in_range;
   logic [7:0]           io_as_data;
   logic                 io_alias_ok;
   logic [7:0]           eff_addr;
   logic                 addr_valid;
   logic                 hit_pc_flags;
   logic                 hit_ext_flags;
   logic                 hit_ext_enables;
   logic                 hit_group_enables;
   logic                 hit_mask_zero;
   logic                 hit_mask_one;
   logic                 hit_mask_two;
   logic [7:0]           read_value;

   // write strobes and write-one-to-clear masks
   logic                 wr_pc_flags;
   logic                 wr_ext_flags;
   logic                 wr_ext_enables;
   logic                 wr_group_enables;
   logic                 wr_mask_zero;
   logic                 wr_mask_one;
   logic                 wr_mask_two;
   logic [1:0]           ext_w1c;
   logic [2:0]           pc_w1c;

   // event and request terms
   logic [1:0]           sense_low;
   logic [1:0]           ext_event;
   logic [1:0]           ext_rise;
   logic [1:0]           ext_fall;
   logic [1:0]           ext_set;
   logic [1:0]           ext_clear;
   logic [1:0]           ext_ack;
   logic [2:0]           pc_event;
   logic [2:0]           pc_clear;
   logic [2:0]           pc_ack;
   logic [23:0]          line_mask;
   logic [1:0]           ext_line_enabled;
   logic [2:0]           group_enabled;
   logic [1:0]           ext_req;
   logic [2:0]           pc_req;
   logic                 next_irq_request;
   epc_vector_t          next_irq_vector;

   // reset is taken asynchronously and released through two flops
   // a synchronous release lets every flop leave reset on the same edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_n <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_n <= 1'b1;
         rst_sync_n <= rst_meta_n;
      end
   end

   // pins are read as inputs whatever the port direction, so a driven
   // pin can raise its own request as a software interrupt
   epc_pin_sync #(
      .WIDTH   (2)
   ) u_ext_sync (
      .clk     (clk),
      .rst_n   (rst_sync_n),
      .pin_in  (external_line),
      .level   (ext_level),
      .changed (ext_changed)
   );

   // pin change lines are sampled every cycle regardless of the core's
   // enables; a truly clockless wake path would sit outside this block
   epc_pin_sync #(
      .WIDTH   (PIN_LINES)
   ) u_pc_sync (
      .clk     (clk),
      .rst_n   (rst_sync_n),
      .pin_in  (pin_change_line),
      .level   (pc_level),
      .changed (pc_changed)
   );

   // i/o space reaches only the two flag registers and the line enables
   // the higher registers have no short form and read zero through it
   assign io_in_range   = bus_req.addr <= IO_SPACE_LIMIT;
   assign io_as_data    = bus_req.addr + IO_SPACE_DISTANCE;
   assign io_alias_ok   = io_in_range &&
                          (io_as_data == OFS_PIN_CHANGE_FLAGS ||
                           io_as_data == OFS_EXTERNAL_IRQ_FLAGS ||
                           io_as_data == OFS_EXTERNAL_IRQ_ENABLES);
   assign eff_addr      = bus_req.io_space ? io_as_data : bus_req.addr;
   assign addr_valid    = !bus_req.io_space || io_alias_ok;

   // register selects
   assign hit_pc_flags      = addr_valid && eff_addr == OFS_PIN_CHANGE_FLAGS;
   assign hit_ext_flags     = addr_valid && eff_addr == OFS_EXTERNAL_IRQ_FLAGS;
   assign hit_ext_enables   = addr_valid && eff_addr == OFS_EXTERNAL_IRQ_ENABLES;
   assign hit_group_enables = addr_valid && eff_addr == OFS_PIN_CHANGE_GROUP_ENABLES;
   assign hit_mask_zero     = addr_valid && eff_addr == OFS_PIN_CHANGE_LINE_MASK_0;
   assign hit_mask_one      = addr_valid && eff_addr == OFS_PIN_CHANGE_LINE_MASK_1;
   assign hit_mask_two      = addr_valid && eff_addr == OFS_PIN_CHANGE_LINE_MASK_2;

   // write strobes; a write to an unmapped place selects nothing
   assign wr_pc_flags      = bus_req.wr && hit_pc_flags;
   assign wr_ext_flags     = bus_req.wr && hit_ext_flags;
   assign wr_ext_enables   = bus_req.wr && hit_ext_enables;
   assign wr_group_enables = bus_req.wr && hit_group_enables;
   assign wr_mask_zero     = bus_req.wr && hit_mask_zero;
   assign wr_mask_one      = bus_req.wr && hit_mask_one;
   assign wr_mask_two      = bus_req.wr && hit_mask_two;

   // read mux; unused bits and unmapped addresses read zero
   assign read_value = hit_pc_flags      ? {5'h00, pin_change_flags} :
                       hit_ext_flags     ? {6'h00, external_irq_flags} :
                       hit_ext_enables   ? {6'h00, external_irq_enables} :
                       hit_group_enables ? {5'h00, pin_change_group_enables} :
                       hit_mask_zero     ? pin_change_line_mask_zero :
                       hit_mask_one      ? {1'b0, pin_change_line_mask_one} :
                       hit_mask_two      ? pin_change_line_mask_two :
                       REG_RESET;

   // read data is registered and appears the cycle after the strobe
   // reads have no side effects, so polling never loses a flag
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bus_rdata <= REG_RESET;
      end else if (bus_req.rd) begin
         bus_rdata <= read_value;
      end
   end

   // external line enables
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         external_irq_enables <= REG_RESET[1:0];
      end else if (wr_ext_enables) begin
         external_irq_enables <= bus_req.wdata[1:0];
      end
   end

   // pin change group enables
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_change_group_enables <= REG_RESET[2:0];
      end else if (wr_group_enables) begin
         pin_change_group_enables <= bus_req.wdata[2:0];
      end
   end

   // per-line masks; group one keeps only seven bits
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pin_change_line_mask_zero <= REG_RESET;
         pin_change_line_mask_one  <= REG_RESET[6:0];
         pin_change_line_mask_two  <= REG_RESET;
      end else begin
         if (wr_mask_zero) begin
            pin_change_line_mask_zero <= bus_req.wdata;
         end
         if (wr_mask_one) begin
            pin_change_line_mask_one <= bus_req.wdata[6:0];
         end
         if (wr_mask_two) begin
            pin_change_line_mask_two <= bus_req.wdata;
         end
      end
   end

   // handler entry, decoded from the acknowledged vector
   // an ack for a code with no source decodes to nothing and is harmless
   assign ext_ack[BIT_LINE_ZERO]  = irq_ack && irq_ack_vector == VEC_LINE_ZERO;
   assign ext_ack[BIT_LINE_ONE]   = irq_ack && irq_ack_vector == VEC_LINE_ONE;
   assign pc_ack[BIT_GROUP_ZERO]  = irq_ack && irq_ack_vector == VEC_GROUP_ZERO;
   assign pc_ack[BIT_GROUP_ONE]   = irq_ack && irq_ack_vector == VEC_GROUP_ONE;
   assign pc_ack[BIT_GROUP_TWO]   = irq_ack && irq_ack_vector == VEC_GROUP_TWO;

   // trigger selection per external line
   assign sense_low[BIT_LINE_ZERO] = line_zero_sense == SENSE_LOW_LEVEL;
   assign sense_low[BIT_LINE_ONE]  = line_one_sense == SENSE_LOW_LEVEL;

   // synchronised edges, one each for the falling and rising sense modes
   assign ext_rise = ext_changed & ext_level;
   assign ext_fall = ext_changed & ~ext_level;

   // short pulses may be missed: the source holds each level over one clock
   assign ext_event[BIT_LINE_ZERO] =
      (line_zero_sense == SENSE_ANY_EDGE && ext_changed[BIT_LINE_ZERO]) ||
      (line_zero_sense == SENSE_FALLING && ext_fall[BIT_LINE_ZERO]) ||
      (line_zero_sense == SENSE_RISING && ext_rise[BIT_LINE_ZERO]);
   assign ext_event[BIT_LINE_ONE] =
      (line_one_sense == SENSE_ANY_EDGE && ext_changed[BIT_LINE_ONE]) ||
      (line_one_sense == SENSE_FALLING && ext_fall[BIT_LINE_ONE]) ||
      (line_one_sense == SENSE_RISING && ext_rise[BIT_LINE_ONE]);

   // write-one-to-clear masks; zero bits leave the flags alone
   assign ext_w1c = wr_ext_flags ? bus_req.wdata[1:0] : 2'h0;
   assign pc_w1c  = wr_pc_flags ? bus_req.wdata[2:0] : 3'h0;

   // level mode never sets the flag and keeps clearing it; edge flags set
   // whatever the enable says, so software can poll a disabled line
   assign ext_set   = ext_event & ~sense_low;
   assign ext_clear = ext_w1c | ext_ack | sense_low;

   epc_flag_bits #(
      .WIDTH (2)
   ) u_ext_flags (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .set   (ext_set),
      .clear (ext_clear),
      .flags (external_irq_flags)
   );

   // line 15 has no mask bit and never contributes
   assign line_mask = {pin_change_line_mask_two, 1'b0,
                       pin_change_line_mask_one, pin_change_line_mask_zero};

   // a change on any enabled line of a group sets the group flag
   assign pc_event[BIT_GROUP_ZERO] =
      |(pc_changed[GROUP_ZERO_LSB +: 8] & line_mask[GROUP_ZERO_LSB +: 8]);
   assign pc_event[BIT_GROUP_ONE]  =
      |(pc_changed[GROUP_ONE_LSB +: GROUP_ONE_BITS] &
        line_mask[GROUP_ONE_LSB +: GROUP_ONE_BITS]);
   assign pc_event[BIT_GROUP_TWO]  =
      |(pc_changed[GROUP_TWO_LSB +: 8] & line_mask[GROUP_TWO_LSB +: 8]);

   assign pc_clear = pc_w1c | pc_ack;

   epc_flag_bits #(
      .WIDTH (3)
   ) u_pc_flags (
      .clk   (clk),
      .rst_n (rst_sync_n),
      .set   (pc_event),
      .clear (pc_clear),
      .flags (pin_change_flags)
   );

   // enables are gated by the core's global enable
   // the group enable gates only the request; flags still collect changes
   assign ext_line_enabled[BIT_LINE_ZERO] = global_irq_enable && external_irq_enables[BIT_LINE_ZERO];
   assign ext_line_enabled[BIT_LINE_ONE]  = global_irq_enable && external_irq_enables[BIT_LINE_ONE];
   assign group_enabled = {3{global_irq_enable}} & pin_change_group_enables;

   // level mode asks for as long as the pin stays low
   assign ext_req[BIT_LINE_ZERO] = ext_line_enabled[BIT_LINE_ZERO] &&
      (sense_low[BIT_LINE_ZERO] ? !ext_level[BIT_LINE_ZERO] : external_irq_flags[BIT_LINE_ZERO]);
   assign ext_req[BIT_LINE_ONE]  = ext_line_enabled[BIT_LINE_ONE] &&
      (sense_low[BIT_LINE_ONE] ? !ext_level[BIT_LINE_ONE] : external_irq_flags[BIT_LINE_ONE]);
   assign pc_req = group_enabled & pin_change_flags;

   // fixed priority, each source with its own vector
   // a line zero held low in level mode starves every other source
   assign next_irq_request = |{pc_req, ext_req};
   assign next_irq_vector  = ext_req[BIT_LINE_ZERO] ? VEC_LINE_ZERO :
                             ext_req[BIT_LINE_ONE]  ? VEC_LINE_ONE :
                             pc_req[BIT_GROUP_ZERO] ? VEC_GROUP_ZERO :
                             pc_req[BIT_GROUP_ONE]  ? VEC_GROUP_ONE :
                             pc_req[BIT_GROUP_TWO]  ? VEC_GROUP_TWO :
                             VEC_LINE_ZERO;

   // a pin edge is sampled, synchronised, flagged and then requested, so
   // the request trails the pin by four edges; an ack clears the flag at
   // its own edge and the request falls one edge later
   // registered request; the core should ignore it the cycle after an ack
   always_ff @(posedge clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_request <= 1'b0;
         irq_vector  <= VEC_LINE_ZERO;
      end else begin
         irq_request <= next_irq_request;
         irq_vector  <= next_irq_vector;
      end
   end

endmodule : epc_irq_ctrl

// ===== tb/epc_pin_source.sv
`timescale 1ns/10ps
// pin sources outside the device; every level is held for whole clocks
module epc_pin_source (
   // clock
   input  wire logic  clk,
   // pins towards the device
   output logic [1:0]  external_line,
   output logic [23:0] pin_change_line
);
   // idle levels: external lines pulled high, change lines low
   initial begin
      external_line   = 2'h3;
      pin_change_line = 24'h000000;
   end

   // change just after an edge, then hold four clocks so no pulse is a runt
   task automatic drive(input logic [1:0] ext, input logic [23:0] pc);
      @(posedge clk);
      #2;
      external_line   = ext;
      pin_change_line = pc;
      repeat (4) @(posedge clk);
   endtask : drive
endmodule : epc_pin_source

// ===== tb/epc_irq_ctrl_monitor.sv
`timescale 1ns/10ps
// passive watch on the controller ports
module epc_irq_ctrl_monitor (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // core side
   input wire logic                  global_irq_enable,
   input wire logic                  irq_request,
   input wire epc_pkg::epc_vector_t  irq_vector,
   // register access
   input wire epc_pkg::epc_bus_req_s bus_req,
   input wire logic [7:0]            bus_rdata,
   // sense selection
   input wire logic [1:0]            line_zero_sense
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // data-space read strobe; io reads are judged separately
   wire rd_ds = bus_req.rd && !bus_req.io_space;

   property p_global_gate;
      !global_irq_enable |=> !irq_request;
   endproperty
   a_global_gate: assert property (p_global_gate)
      else $error("request while global enable low");
   property p_vec_idle;
      !irq_request |-> irq_vector == 3'h0;
   endproperty
   a_vec_idle: assert property (p_vec_idle)
      else $error("vector not zero while idle");
   property p_vec_range;
      irq_request |-> irq_vector <= 3'h4;
   endproperty
   a_vec_range: assert property (p_vec_range)
      else $error("vector out of range");
   property p_unmapped;
      rd_ds && bus_req.addr == 8'h40 |=> bus_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_io_unmapped;
      bus_req.rd && bus_req.io_space && bus_req.addr == 8'h3d |=> bus_rdata == 8'h00;
   endproperty
   a_io_unmapped: assert property (p_io_unmapped)
      else $error("io read beyond alias not zero");
   property p_mask_one_top;
      rd_ds && bus_req.addr == 8'h6c |=> !bus_rdata[7];
   endproperty
   a_mask_one_top: assert property (p_mask_one_top)
      else $error("group one mask bit 7 set");
   property p_ext_flag_width;
      rd_ds && bus_req.addr == 8'h3c |=> bus_rdata[7:2] == 6'h00;
   endproperty
   a_ext_flag_width: assert property (p_ext_flag_width)
      else $error("external flag upper bits set");
   property p_pc_flag_width;
      rd_ds && bus_req.addr == 8'h3b |=> bus_rdata[7:3] == 5'h00;
   endproperty
   a_pc_flag_width: assert property (p_pc_flag_width)
      else $error("pin change flag upper bits set");
   property p_level_flag;
      (line_zero_sense == 2'h0) [*3] ##0 (rd_ds && bus_req.addr == 8'h3c) |=> !bus_rdata[0];
   endproperty
   a_level_flag: assert property (p_level_flag)
      else $error("line zero flag set in level mode");
endmodule : epc_irq_ctrl_monitor

bind epc_irq_ctrl epc_irq_ctrl_monitor mon_u (
   .clk               (clk),
   .rst_n             (rst_n),
   .global_irq_enable (global_irq_enable),
   .irq_request       (irq_request),
   .irq_vector        (irq_vector),
   .bus_req           (bus_req),
   .bus_rdata         (bus_rdata),
   .line_zero_sense   (line_zero_sense)
);

// ===== tb/epc_irq_ctrl_test.sv
`timescale 1ns/10ps
// self-checking bench for the external and pin change interrupt controller
module epc_irq_ctrl_test;
   import epc_pkg::*;
   // one register step: space, address, value before, data written, value after
   typedef struct packed {
      logic io; logic [7:0] addr; logic [7:0] pre; logic [7:0] wdata; logic [7:0] post;
   } epc_row_s;
   logic         clk               = 1'b0;
   logic         rst_n             = 1'b0;
   logic         global_irq_enable = 1'b0;
   logic         irq_ack           = 1'b0;
   epc_vector_t  irq_ack_vector    = 3'h0;
   epc_bus_req_s bus_req           = '0;
   logic [1:0]   line_zero_sense   = 2'h3;
   logic [1:0]   line_one_sense    = 2'h3;
   logic         irq_request;
   epc_vector_t  irq_vector;
   logic [7:0]   bus_rdata;
   logic [1:0]   external_line;
   logic [23:0]  pin_change_line;
   logic [7:0]   rd_val;
   int           failures = 0;
   int           checks   = 0;
   // flags read zero and ignore zero writes; unmapped places read zero
   epc_row_s rows [10] = '{
      '{1'b0, 8'h3b, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h3c, 8'h00, 8'h00, 8'h00},
      '{1'b1, 8'h1d, 8'h00, 8'h01, 8'h01}, '{1'b0, 8'h3d, 8'h01, 8'hff, 8'h03},
      '{1'b0, 8'h68, 8'h00, 8'hff, 8'h07}, '{1'b0, 8'h6b, 8'h00, 8'ha5, 8'ha5},
      '{1'b0, 8'h6c, 8'h00, 8'hff, 8'h7f}, '{1'b0, 8'h6d, 8'h00, 8'h5a, 8'h5a},
      '{1'b0, 8'h40, 8'h00, 8'hff, 8'h00}, '{1'b1, 8'h3d, 8'h00, 8'hff, 8'h00}};

   epc_irq_ctrl dut_u (.clk(clk), .rst_n(rst_n), .global_irq_enable(global_irq_enable),
      .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector), .irq_request(irq_request),
      .irq_vector(irq_vector), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .line_zero_sense(line_zero_sense), .line_one_sense(line_one_sense),
      .external_line(external_line), .pin_change_line(pin_change_line));
   epc_pin_source src_u (.clk(clk), .external_line(external_line), .pin_change_line(pin_change_line));

   // 40 MHz clock
   always #12.5 clk = ~clk;

   // one register cycle; read data is taken after the strobe edge has landed
   task automatic acc(input logic rd, input logic wr, input logic io, input logic [7:0] addr,
                      input logic [7:0] data);
      @(posedge clk);
      #2;
      bus_req = '{addr: addr, io_space: io, wr: wr, rd: rd, wdata: data};
      @(posedge clk);
      #2;
      bus_req = '0;
      rd_val  = bus_rdata;
   endtask : acc
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic rdchk(input logic io, input logic [7:0] addr, input logic [7:0] exp);
      acc(1'b1, 1'b0, io, addr, 8'h00);
      chk(rd_val, exp);
   endtask : rdchk
   // bounded wait for the request level, then compare it with the vector
   task automatic wait_req(input logic exp, input epc_vector_t vec);
      @(posedge clk);
      #2;
      for (int n = 0; n < 8 && irq_request !== exp; n++) begin
         @(posedge clk);
         #2;
      end
      chk({4'h0, irq_request, irq_vector}, {4'h0, exp, vec});
   endtask : wait_req
   task automatic ack(input epc_vector_t vec);
      @(posedge clk);
      #2;
      irq_ack        = 1'b1;
      irq_ack_vector = vec;
      @(posedge clk);
      #2;
      irq_ack = 1'b0;
   endtask : ack
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test

   // watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      #(25 * 4000);
      failures++;
      stop_test();
   end

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      #2;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      foreach (rows[i]) begin
         rdchk(rows[i].io, rows[i].addr, rows[i].pre);
         acc(1'b0, 1'b1, rows[i].io, rows[i].addr, rows[i].wdata);
         rdchk(rows[i].io, rows[i].addr, rows[i].post);
      end
      global_irq_enable = 1'b1;
      // group zero request, removed by handler entry
      src_u.drive(2'h3, 24'h000001);
      wait_req(1'b1, VEC_GROUP_ZERO);
      rdchk(1'b0, OFS_PIN_CHANGE_FLAGS, 8'h01);
      ack(VEC_GROUP_ZERO);
      wait_req(1'b0, 3'h0);
      rdchk(1'b0, OFS_PIN_CHANGE_FLAGS, 8'h00);
      // masked line 1 and the unused line 15 stay silent
      src_u.drive(2'h3, 24'h008003);
      rdchk(1'b0, OFS_PIN_CHANGE_FLAGS, 8'h00);
      src_u.drive(2'h3, 24'h008103);
      wait_req(1'b1, VEC_GROUP_ONE);
      acc(1'b0, 1'b1, 1'b0, OFS_PIN_CHANGE_FLAGS, 8'h02);
      rdchk(1'b0, OFS_PIN_CHANGE_FLAGS, 8'h00);
      // group two request, then the global enable withdrawn while the flag stays
      src_u.drive(2'h3, 24'h028103);
      wait_req(1'b1, VEC_GROUP_TWO);
      global_irq_enable = 1'b0;
      wait_req(1'b0, 3'h0);
      rdchk(1'b0, OFS_PIN_CHANGE_FLAGS, 8'h04);
      acc(1'b0, 1'b1, 1'b0, OFS_PIN_CHANGE_FLAGS, 8'h04);
      global_irq_enable = 1'b1;
      // line one through change, falling and rising sense
      for (int m = 1; m < 4; m++) begin
         line_one_sense = m[1:0];
         src_u.drive(2'h1, 24'h028103);
         rdchk(1'b0, OFS_EXTERNAL_IRQ_FLAGS, (m != 3) ? 8'h02 : 8'h00);
         acc(1'b0, 1'b1, 1'b0, OFS_EXTERNAL_IRQ_FLAGS, 8'h02);
         src_u.drive(2'h3, 24'h028103);
         rdchk(1'b0, OFS_EXTERNAL_IRQ_FLAGS, (m != 2) ? 8'h02 : 8'h00);
         if (m != 2) wait_req(1'b1, VEC_LINE_ONE);
         ack(VEC_LINE_ONE);
         rdchk(1'b0, OFS_EXTERNAL_IRQ_FLAGS, 8'h00);
      end
      // line zero rising edge with its enable withheld, then granted
      acc(1'b0, 1'b1, 1'b0, OFS_EXTERNAL_IRQ_ENABLES, 8'h02);
      src_u.drive(2'h2, 24'h028103);
      src_u.drive(2'h3, 24'h028103);
      rdchk(1'b0, OFS_EXTERNAL_IRQ_FLAGS, 8'h01);
      wait_req(1'b0, 3'h0);
      acc(1'b0, 1'b1, 1'b0, OFS_EXTERNAL_IRQ_ENABLES, 8'h03);
      wait_req(1'b1, VEC_LINE_ZERO);
      ack(VEC_LINE_ZERO);
      rdchk(1'b0, OFS_EXTERNAL_IRQ_FLAGS, 8'h00);
      // low level keeps requesting while the pin stays low, flag held clear
      line_zero_sense = SENSE_LOW_LEVEL;
      src_u.drive(2'h2, 24'h028103);
      wait_req(1'b1, VEC_LINE_ZERO);
      rdchk(1'b0, OFS_EXTERNAL_IRQ_FLAGS, 8'h00);
      wait_req(1'b1, VEC_LINE_ZERO);
      src_u.drive(2'h3, 24'h028103);
      wait_req(1'b0, 3'h0);
      stop_test();
   end
endmodule : epc_irq_ctrl_test
